//--- common/ecil_pkg.sv
package ecil_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int          ECIL_NUM_CH   = 8;
  localparam int          ECIL_ADDR_W   = 8;
  localparam int          ECIL_DATA_W   = 32;
  localparam int          ECIL_PATH_W   = 2;
  localparam int          ECIL_VEC_W    = 16;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0]  ECIL_OFF_IEN_CLR  = 8'h10;
  localparam logic [7:0]  ECIL_OFF_IEN_SET  = 8'h14;
  localparam logic [7:0]  ECIL_OFF_FLAG     = 8'h18;
  localparam logic [7:0]  ECIL_OFF_EVT_STS  = 8'h1c;
  localparam logic [7:0]  ECIL_OFF_EVT_MASK = 8'h20;
  localparam logic [7:0]  ECIL_OFF_PATH     = 8'h24;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [15:0] ECIL_VEC_RST      = 16'h0000;
  localparam logic [15:0] ECIL_PATH_RST     = 16'h0000;
  localparam logic [1:0]  ECIL_PATH_SYNC    = 2'h0;
  localparam logic [1:0]  ECIL_PATH_RESYNC  = 2'h1;
  localparam logic [1:0]  ECIL_PATH_ASYNC   = 2'h2;
  localparam logic [1:0]  ECIL_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  ECIL_RESP_SLVERR  = 2'h2;
  localparam logic [31:0] ECIL_RDATA_RST    = 32'h0000_0000;

  // Event-detected in upper byte, overrun in lower byte
  typedef struct packed {
    logic [7:0] evd;
    logic [7:0] ovr;
  } ecil_irq_vec_s;

endpackage : ecil_pkg

//--- hdl/ecil_flag_core.sv
`timescale 1ns/1ps
`default_nettype none

module ecil_flag_core
  import ecil_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Channel activity
  input  wire logic [7:0]            channel_event_detected,
  input  wire logic [7:0]            channel_overrun,
  input  wire logic [15:0]           path_sel,
  // Software clear and flag state
  input  wire ecil_irq_vec_s         flag_clr,
  output var  ecil_irq_vec_s         flag_q,
  output var  ecil_irq_vec_s         flag_set
);

  ecil_irq_vec_s flag_reg;
  ecil_irq_vec_s flag_next;
  ecil_irq_vec_s set_vec;

  // ****************************************
  // Per-channel flags
  // ****************************************
  // two flags per channel
  genvar ch;
  generate
    for (ch = 0; ch < ECIL_NUM_CH; ch++) begin : g_ch
      logic is_async;
      assign is_async = (path_sel[ch*ECIL_PATH_W +: ECIL_PATH_W] == ECIL_PATH_ASYNC);
      assign set_vec.evd[ch] = channel_event_detected[ch] & ~is_async;
      assign set_vec.ovr[ch] = channel_overrun[ch] & ~is_async;
    end
  endgenerate

  always_comb begin
    // clear only on one, set wins
    flag_next = (flag_reg & ~flag_clr) | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= ECIL_VEC_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_q   = flag_reg;
  assign flag_set = set_vec;

endmodule : ecil_flag_core

`default_nettype wire

//--- hdl/ecil_top.sv
// Contract
// - Eight channels, each with event flag (upper byte) and overrun flag (lower byte).
// - Writing one to enable-clear event bit disables that channel's event interrupt.
// - Writing one to enable-clear overrun bit disables that channel's overrun interrupt.
// - Writing one to enable-set event bit enables that channel's event interrupt.
// - Writing one to enable-set overrun bit enables that channel's overrun interrupt.
// - Reading enable-set or enable-clear returns current enables, one meaning enabled.
// - Writing zero to enable or flag bits changes nothing.
// - Event flag sets on the next bus clock while an event passes.
// - Event interrupt requested only when flag and its enable are both set; the code also raises irq when event status and its mask bit are both set.
// - Overrun flag sets next channel clock after overrun; interrupts if enabled.
// - Event flag never sets on a channel using the asynchronous path.
// - Overrun flag never sets on a channel using the asynchronous path.
// - Writing one to a flag register event bit clears that event flag.
// - Writing one to a flag register overrun bit clears that overrun flag.
// - Path select two means asynchronous; zero synchronous, one resynchronized.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ecil_top
  import ecil_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Channel activity
  input  wire logic [7:0]              channel_event_detected,
  input  wire logic [7:0]              channel_overrun,
  // Path select per channel
  output logic [15:0]                  channel_path,
  // Interrupt request
  output logic                         irq,
  // AXI4-Lite write address
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [ECIL_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [ECIL_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [ECIL_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  // AXI4-Lite read data
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [ECIL_DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                   s_axi_rresp
);

  // ****************************************
  // State
  // ****************************************
  logic                    aw_full_reg;
  logic                    aw_full_next;
  logic [ECIL_ADDR_W-1:0]  awaddr_reg;
  logic [ECIL_ADDR_W-1:0]  awaddr_next;
  logic                    w_full_reg;
  logic                    w_full_next;
  logic [ECIL_DATA_W-1:0]  wdata_reg;
  logic [ECIL_DATA_W-1:0]  wdata_next;
  logic [3:0]              wstrb_reg;
  logic [3:0]              wstrb_next;
  logic                    awready_reg;
  logic                    awready_next;
  logic                    wready_reg;
  logic                    wready_next;
  logic                    bvalid_reg;
  logic                    bvalid_next;
  logic [1:0]              bresp_reg;
  logic [1:0]              bresp_next;
  logic                    arready_reg;
  logic                    arready_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic [ECIL_DATA_W-1:0]  rdata_reg;
  logic [ECIL_DATA_W-1:0]  rdata_next;
  logic [1:0]              rresp_reg;
  logic [1:0]              rresp_next;

  ecil_irq_vec_s           ien_reg;
  ecil_irq_vec_s           ien_next;
  ecil_irq_vec_s           sts_reg;
  ecil_irq_vec_s           sts_next;
  ecil_irq_vec_s           mask_reg;
  ecil_irq_vec_s           mask_next;
  logic [15:0]             path_reg;
  logic [15:0]             path_next;
  logic                    irq_reg;
  logic                    irq_next;

  // ****************************************
  // Flag core
  // ****************************************
  ecil_irq_vec_s           flag_q;
  ecil_irq_vec_s           flag_set;
  ecil_irq_vec_s           flag_clr;

  ecil_flag_core u_flag_core (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .channel_event_detected (channel_event_detected),
    .channel_overrun        (channel_overrun),
    .path_sel               (path_reg),
    .flag_clr               (flag_clr),
    .flag_q                 (flag_q),
    .flag_set               (flag_set)
  );

  // ****************************************
  // Write channel
  // ****************************************
  logic                    aw_take;
  logic                    w_take;
  logic                    wr_fire;
  logic [ECIL_ADDR_W-1:0]  wr_addr;
  logic [ECIL_DATA_W-1:0]  wr_data;
  logic [3:0]              wr_strb;
  logic [15:0]             wr_bits;
  logic                    wr_hit;

  always_comb begin
    aw_take      = s_axi_awvalid & awready_reg;
    w_take       = s_axi_wvalid & wready_reg;
    aw_full_next = aw_full_reg | aw_take;
    w_full_next  = w_full_reg | w_take;
    awaddr_next  = aw_take ? s_axi_awaddr : awaddr_reg;
    wdata_next   = w_take ? s_axi_wdata : wdata_reg;
    wstrb_next   = w_take ? s_axi_wstrb : wstrb_reg;
    wr_addr      = awaddr_next;
    wr_data      = wdata_next;
    wr_strb      = wstrb_next;
    // Either order: fire once both halves are held
    wr_fire      = aw_full_next & w_full_next & ~bvalid_reg;
    // Only the two low byte lanes carry register bits
    wr_bits      = wr_data[15:0] & {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    case (wr_addr)
      ECIL_OFF_IEN_CLR,
      ECIL_OFF_IEN_SET,
      ECIL_OFF_FLAG,
      ECIL_OFF_EVT_STS,
      ECIL_OFF_EVT_MASK,
      ECIL_OFF_PATH: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next  = bresp_reg;
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? ECIL_RESP_OKAY : ECIL_RESP_SLVERR;
    end
    // Stall both halves while a response waits
    awready_next = ~aw_full_next & ~bvalid_next;
    wready_next  = ~w_full_next & ~bvalid_next;
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic                    ar_take;
  logic                    rd_sts_clr;

  always_comb begin
    ar_take     = s_axi_arvalid & arready_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    rd_sts_clr  = 1'b0;
    if (ar_take) begin
      rvalid_next = 1'b1;
      rresp_next  = ECIL_RESP_OKAY;
      case (s_axi_araddr)
        // both enable views read back enables
        ECIL_OFF_IEN_CLR,
        ECIL_OFF_IEN_SET: begin
          rdata_next = {16'h0000, ien_reg};
        end
        ECIL_OFF_FLAG: begin
          rdata_next = {16'h0000, flag_q};
        end
        ECIL_OFF_EVT_STS: begin
          rdata_next = {16'h0000, sts_reg};
          rd_sts_clr = 1'b1;
        end
        ECIL_OFF_EVT_MASK: begin
          rdata_next = {16'h0000, mask_reg};
        end
        ECIL_OFF_PATH: begin
          rdata_next = {16'h0000, path_reg};
        end
        default: begin
          rdata_next = ECIL_RDATA_RST;
          rresp_next = ECIL_RESP_SLVERR;
        end
      endcase
    end
    arready_next = ~rvalid_next;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    ien_next  = ien_reg;
    mask_next = mask_reg;
    path_next = path_reg;
    flag_clr  = ECIL_VEC_RST;
    if (wr_fire) begin
      case (wr_addr)
        ECIL_OFF_IEN_CLR: begin
          ien_next = ien_reg & ~wr_bits;
        end
        ECIL_OFF_IEN_SET: begin
          ien_next = ien_reg | wr_bits;
        end
        ECIL_OFF_FLAG: begin
          flag_clr = wr_bits;
        end
        ECIL_OFF_EVT_MASK: begin
          mask_next = (mask_reg & ~{{8{wr_strb[1]}}, {8{wr_strb[0]}}}) | wr_bits;
        end
        ECIL_OFF_PATH: begin
          path_next = (path_reg & ~{{8{wr_strb[1]}}, {8{wr_strb[0]}}}) | wr_bits;
        end
        default: begin
          ien_next = ien_reg;
        end
      endcase
    end
  end

  // ****************************************
  // Sticky event status and interrupt
  // ****************************************
  always_comb begin
    // A new event in the reading cycle survives the clear
    sts_next = (rd_sts_clr ? ECIL_VEC_RST : sts_reg) | flag_set;
    // flag and enable per source, ORed with status and mask per source
    irq_next = (|(flag_q & ien_reg)) | (|(sts_reg & mask_reg));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_full_reg  <= 1'b0;
      wdata_reg   <= ECIL_RDATA_RST;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= ECIL_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= ECIL_RDATA_RST;
      rresp_reg   <= ECIL_RESP_OKAY;
      ien_reg     <= ECIL_VEC_RST;
      sts_reg     <= ECIL_VEC_RST;
      mask_reg    <= ECIL_VEC_RST;
      path_reg    <= ECIL_PATH_RST;
      irq_reg     <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ien_reg     <= ien_next;
      sts_reg     <= sts_next;
      mask_reg    <= mask_next;
      path_reg    <= path_next;
      irq_reg     <= irq_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign channel_path  = path_reg;
  assign irq           = irq_reg;

endmodule : ecil_top

`default_nettype wire

//--- tb/ecil_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ecil_monitor
  import ecil_pkg::*;
(
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // Channels and interrupt
  input wire logic [7:0]             channel_event_detected,
  input wire logic [7:0]             channel_overrun,
  input wire logic [15:0]            channel_path,
  input wire logic                   irq,
  // Register bus
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [ECIL_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]             s_axi_rresp
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
  // path only by write
  // Tied to the response, so a late data half cannot trip it
  a_path_hold: assert property ($changed(channel_path) |-> $rose(s_axi_bvalid) || $past(rst))
    else $error("path changed alone");
  a_irq_source: assert property ($rose(irq) |-> $past(channel_event_detected != 8'h00
    || channel_overrun != 8'h00, 2) || s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq without cause");
  a_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || s_axi_rvalid
    || $past(s_axi_rvalid) || $past(rst)) else $error("irq fell alone");
endmodule : ecil_monitor

`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ecil_pkg::*;
;
  logic        clk_sys, rst, irq;
  logic [7:0]  channel_event_detected, channel_overrun, s_axi_awaddr, s_axi_araddr;
  logic [15:0] channel_path;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, ex;
  int          error_cnt, compares;

  ecil_top dut (.*);

  always #12.5 clk_sys = ~clk_sys;

  // *****
  // Checks and bus tasks
  // *****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Every bus wait is bounded so a dead slave cannot hang the run
  task automatic tick(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > 60) begin
      error_cnt++;
      $display("mismatch at %0t: bus timeout", $time);
      print_verdict();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = ECIL_RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    int   n;
    logic ad, dd;
    n = 0;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      tick(n);
      if (s_axi_awready === 1'b1 && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !dd) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Late ready makes the slave hold its response
    tick(n);
    s_axi_bready <= 1'b1;
    do tick(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = ECIL_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    tick(n);
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask : rd

  task automatic pulse(input logic [15:0] v);
    @(posedge clk_sys);
    {channel_event_detected, channel_overrun} <= v;
    @(posedge clk_sys);
    {channel_event_detected, channel_overrun} <= 16'h0000;
  endtask : pulse

  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk_sys);
    chk(32'(irq), 32'(v));
  endtask : irq_is

  // *****
  // Sequence
  // *****
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {channel_event_detected, channel_overrun, s_axi_awaddr, s_axi_araddr} = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
    s_axi_wstrb = 4'hf;
    ex = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(ECIL_OFF_IEN_SET, 32'h0);
    rd(ECIL_OFF_FLAG, 32'h0);
    rd(8'h30, 32'h0, ECIL_RESP_SLVERR);
    wr(8'h31, 32'hffff, ECIL_RESP_SLVERR);
    for (int n = 0; n < 8; n++) begin
      ex |= 32'h0101 << n;
      wr(ECIL_OFF_IEN_SET, 32'h0101 << n);
      rd(ECIL_OFF_IEN_CLR, ex);
    end
    wr(ECIL_OFF_IEN_SET, 32'h0);
    wr(ECIL_OFF_IEN_CLR, 32'h00f0);
    rd(ECIL_OFF_IEN_SET, 32'hff0f);
    wr(ECIL_OFF_IEN_CLR, 32'hff0f);
    rd(ECIL_OFF_IEN_CLR, 32'h0);
    // Walk every flag bit through set, enable and clear
    for (int j = 0; j < 16; j++) begin
      pulse(16'h1 << j);
      rd(ECIL_OFF_FLAG, 32'h1 << j);
      irq_is(1'b0);
      wr(ECIL_OFF_IEN_SET, 32'h1 << j);
      irq_is(1'b1);
      wr(ECIL_OFF_FLAG, 32'hffff ^ (32'h1 << j));
      rd(ECIL_OFF_FLAG, 32'h1 << j);
      wr(ECIL_OFF_FLAG, 32'h1 << j);
      irq_is(1'b0);
      wr(ECIL_OFF_IEN_CLR, 32'h1 << j);
    end
    wr(ECIL_OFF_PATH, 32'haaaa);
    chk(32'(channel_path), 32'haaaa);
    wr(ECIL_OFF_IEN_SET, 32'hffff);
    pulse(16'hffff);
    rd(ECIL_OFF_FLAG, 32'h0);
    irq_is(1'b0);
    wr(ECIL_OFF_PATH, 32'h50a0);
    pulse(16'hffff);
    rd(ECIL_OFF_FLAG, 32'hf3f3);
    irq_is(1'b1);
    wr(ECIL_OFF_FLAG, 32'hffff);
    wr(ECIL_OFF_IEN_CLR, 32'hffff);
    irq_is(1'b0);
    // Status clears on read; mask routes it to the line
    rd(ECIL_OFF_EVT_STS, 32'hffff);
    rd(ECIL_OFF_EVT_STS, 32'h0);
    wr(ECIL_OFF_EVT_MASK, 32'h0100);
    rd(ECIL_OFF_EVT_MASK, 32'h0100);
    pulse(16'h0100);
    irq_is(1'b1);
    rd(ECIL_OFF_EVT_STS, 32'h0100);
    irq_is(1'b0);
    // Only the strobed byte lane may change
    wr(ECIL_OFF_EVT_MASK, 32'hffff, ECIL_RESP_OKAY, 4'h1);
    rd(ECIL_OFF_EVT_MASK, 32'h01ff);
    print_verdict();
  end
endmodule : tb_top

bind ecil_top ecil_monitor u_mon (.*);

`default_nettype wire
